// file: logic/dual_supply_control_regs.sv
`timescale 1ns/10ps
// Overview of operation
// RULE_01 - control bytes read back last written value
// RULE_02 - first byte: low nibble A, high B
// RULE_03 - tone bits enable gated tone outputs
// RULE_04 - bits 1 and 5 select low power
// RULE_05 - host sets low power only without tone
// RULE_06 - bits 2 and 6 pick tone input kind
// RULE_07 - host writes zero to bits 3, 7
// RULE_08 - write data bytes go to successive addresses
// RULE_09 - read streams successive bytes while master acks
// RULE_10 - stored bits drive control outputs continuously
module dual_supply_control_regs #(
    parameter logic [6:0] CHIP_ADDR = 7'h5A // arbitrary bus address
) (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // serial bus pins, open drain
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // tone gate pins per channel
    input wire logic tone_gate_input_a,
    input wire logic tone_gate_input_b,
    // channel A controls
    output logic [3:0] volt_pick_a,
    output logic tone_on_a,
    output logic low_power_a,
    output logic tone_input_kind_a,
    output logic tone_drive_a,
    // channel B controls
    output logic [3:0] volt_pick_b,
    output logic tone_on_b,
    output logic low_power_b,
    output logic tone_input_kind_b,
    output logic tone_drive_b
);

    logic [3:0] pins_s; // synchronised scl, sda, gate a, gate b
    logic scl_s, sda_s, gate_a_s, gate_b_s;
    logic scl_d, sda_d; // delayed copies for edge detection
    logic scl_rise, scl_fall, bus_start, bus_stop;
    supply_ctrl_pkg::slave_state_t state, ack_next;
    logic [2:0] bit_cnt;
    logic [7:0] rx_shift;
    logic [7:0] tx_shift;
    logic [7:0] ptr; // internal register pointer
    logic ack_drive; // pulling sda low for an acknowledge
    logic mack_ok; // master acknowledged the last byte
    logic [7:0] volt_reg, tone_reg;
    logic [7:0] rx_byte; // byte completed at this scl rise
    logic byte_done;
    logic wr_en; // one-cycle store strobe
    logic load_tx; // one-cycle load of the transmit shifter
    logic [7:0] read_data;
    logic next_sda_oe;

    // all pins pass two flops before any logic looks at them
    pin_sync #(.WIDTH(4), .RESET_VAL(supply_ctrl_pkg::BUS_IDLE)) u_sync (
        .clk(clk), .resetn(resetn),
        .pin_in({scl_in, sda_in, tone_gate_input_a, tone_gate_input_b}),
        .pin_sync_out(pins_s)
    );
    assign {scl_s, sda_s, gate_a_s, gate_b_s} = pins_s;
    // delayed line copies
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            scl_d <= supply_ctrl_pkg::BUS_IDLE;
            sda_d <= supply_ctrl_pkg::BUS_IDLE;
        end
        else
        begin
            scl_d <= scl_s;
            sda_d <= sda_s;
        end
    end
    // bus events; sda only moves while scl is low except start and stop
    assign scl_rise = scl_s & ~scl_d;
    assign scl_fall = ~scl_s & scl_d;
    assign bus_start = scl_s & scl_d & sda_d & ~sda_s;
    assign bus_stop = scl_s & scl_d & ~sda_d & sda_s;
    assign rx_byte = {rx_shift[6:0], sda_s};
    assign byte_done = scl_rise && (bit_cnt == supply_ctrl_pkg::LAST_BIT);
    assign wr_en = byte_done && (state == supply_ctrl_pkg::ST_WDATA); // RULE_08
    assign load_tx = scl_fall && ((state == supply_ctrl_pkg::ST_ACK && ack_drive
        && ack_next == supply_ctrl_pkg::ST_TX)
        || (state == supply_ctrl_pkg::ST_MACK && mack_ok));
    // read mux; unmapped addresses read as a fixed value
    always_comb
    begin
        case (ptr)
            supply_ctrl_pkg::REG_VOLT: read_data = volt_reg; // RULE_01
            supply_ctrl_pkg::REG_TONE: read_data = tone_reg; // RULE_01
            default: read_data = supply_ctrl_pkg::READ_UNMAPPED;
        endcase
    end

    // slave sequencer: start and stop override every state
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            state <= supply_ctrl_pkg::ST_IDLE;
            ack_next <= supply_ctrl_pkg::ST_IDLE;
            bit_cnt <= 3'h0;
            rx_shift <= 8'h00;
            ack_drive <= 1'b0;
            mack_ok <= 1'b0;
        end
        else if (bus_start)
        begin
            state <= supply_ctrl_pkg::ST_CHIP;
            bit_cnt <= 3'h0;
            ack_drive <= 1'b0;
            mack_ok <= 1'b0;
        end
        else if (bus_stop)
        begin
            state <= supply_ctrl_pkg::ST_IDLE;
            ack_drive <= 1'b0;
            mack_ok <= 1'b0;
        end
        else
        begin
            case (state)
                supply_ctrl_pkg::ST_CHIP, supply_ctrl_pkg::ST_REG, supply_ctrl_pkg::ST_WDATA:
                begin
                    if (scl_rise)
                    begin
                        rx_shift <= rx_byte;
                        bit_cnt <= bit_cnt + 3'h1;
                    end
                    if (byte_done && state == supply_ctrl_pkg::ST_CHIP)
                    begin
                        // a foreign address leaves the bus alone until the next start
                        if (rx_byte[7:1] != CHIP_ADDR)
                            state <= supply_ctrl_pkg::ST_IDLE;
                        else
                        begin
                            state <= supply_ctrl_pkg::ST_ACK;
                            ack_next <= rx_byte[0] ? supply_ctrl_pkg::ST_TX
                                : supply_ctrl_pkg::ST_REG;
                        end
                    end
                    else if (byte_done)
                    begin
                        state <= supply_ctrl_pkg::ST_ACK;
                        ack_next <= supply_ctrl_pkg::ST_WDATA;
                    end
                end
                supply_ctrl_pkg::ST_ACK:
                begin
                    // first fall pulls sda low, second fall releases it
                    if (scl_fall && !ack_drive)
                        ack_drive <= 1'b1;
                    else if (scl_fall)
                    begin
                        ack_drive <= 1'b0;
                        state <= ack_next;
                        bit_cnt <= 3'h0;
                    end
                end
                supply_ctrl_pkg::ST_TX:
                begin
                    if (scl_fall && bit_cnt == supply_ctrl_pkg::LAST_BIT)
                        state <= supply_ctrl_pkg::ST_MACK;
                    else if (scl_fall)
                        bit_cnt <= bit_cnt + 3'h1;
                end
                supply_ctrl_pkg::ST_MACK:
                begin
                    // a high acknowledge ends the read; the master then stops
                    if (scl_rise && !sda_s)
                        mack_ok <= 1'b1;
                    else if (scl_rise)
                        state <= supply_ctrl_pkg::ST_IDLE;
                    if (scl_fall && mack_ok)
                    begin
                        mack_ok <= 1'b0;
                        state <= supply_ctrl_pkg::ST_TX;
                        bit_cnt <= 3'h0;
                    end
                end
                default: state <= supply_ctrl_pkg::ST_IDLE;
            endcase
        end
    end

    // pointer: loaded by the address byte, stepped after each byte written and each read byte the master acks
    always_ff @(posedge clk)
    begin
        if (!resetn)
            ptr <= 8'h00;
        else if (byte_done && state == supply_ctrl_pkg::ST_REG)
            ptr <= rx_byte;
        else if (wr_en)
            ptr <= ptr + supply_ctrl_pkg::PTR_STEP; // RULE_08
        else if (state == supply_ctrl_pkg::ST_MACK && scl_rise && !sda_s)
            ptr <= ptr + supply_ctrl_pkg::PTR_STEP; // RULE_09
    end

    // transmit shifter, msb first, loaded on the fall that opens a byte
    always_ff @(posedge clk)
    begin
        if (!resetn)
            tx_shift <= 8'h00;
        else if (load_tx)
            tx_shift <= read_data; // RULE_09
        else if (state == supply_ctrl_pkg::ST_TX && scl_fall)
            tx_shift <= {tx_shift[6:0], 1'b0};
    end

    // open-drain driver: only ever pulls low
    assign next_sda_oe = (state == supply_ctrl_pkg::ST_ACK && ack_drive)
        || (state == supply_ctrl_pkg::ST_TX && !tx_shift[7]);
    always_ff @(posedge clk)
    begin
        if (!resetn)
            sda_oe <= 1'b0;
        else
            sda_oe <= next_sda_oe;
    end
    assign sda_out = 1'b0;

    // control bytes; reserved bits are stored as written
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            volt_reg <= supply_ctrl_pkg::CTRL_RESET;
            tone_reg <= supply_ctrl_pkg::CTRL_RESET;
        end
        else if (wr_en && ptr == supply_ctrl_pkg::REG_VOLT)
            volt_reg <= rx_byte; // RULE_01
        else if (wr_en && ptr == supply_ctrl_pkg::REG_TONE)
            tone_reg <= rx_byte; // RULE_01
    end

    // control outputs follow the stored bits with no extra delay
    assign volt_pick_a = volt_reg[supply_ctrl_pkg::VOLT_A_LSB+:supply_ctrl_pkg::VOLT_W]; // RULE_02
    assign volt_pick_b = volt_reg[supply_ctrl_pkg::VOLT_B_LSB+:supply_ctrl_pkg::VOLT_W]; // RULE_02
    assign tone_on_a = tone_reg[supply_ctrl_pkg::TONE_ON_A]; // RULE_10
    assign tone_on_b = tone_reg[supply_ctrl_pkg::TONE_ON_B]; // RULE_10
    assign low_power_a = tone_reg[supply_ctrl_pkg::LOW_PWR_A]; // RULE_04
    assign low_power_b = tone_reg[supply_ctrl_pkg::LOW_PWR_B]; // RULE_04
    assign tone_input_kind_a = tone_reg[supply_ctrl_pkg::KIND_A]; // RULE_06
    assign tone_input_kind_b = tone_reg[supply_ctrl_pkg::KIND_B]; // RULE_06
    // gated tone; low power with tone on is not blocked, the host avoids it
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            tone_drive_a <= 1'b0;
            tone_drive_b <= 1'b0;
        end
        else
        begin
            tone_drive_a <= tone_on_a & gate_a_s; // RULE_03
            tone_drive_b <= tone_on_b & gate_b_s; // RULE_03
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    sequence s_volt_write;
        wr_en && ptr == supply_ctrl_pkg::REG_VOLT;
    endsequence
    sequence s_tone_write;
        wr_en && ptr == supply_ctrl_pkg::REG_TONE;
    endsequence
    a_read_back_byte: assert property (load_tx |=> tx_shift == $past(read_data)) // RULE_01
        else $error("transmit byte differs from register content");
    a_volt_nibbles: assert property (s_volt_write |=> volt_pick_a == $past(rx_byte[3:0])
        && volt_pick_b == $past(rx_byte[7:4])) // RULE_02
        else $error("voltage nibbles not taken from written byte");
    a_tone_gate_off: assert property (!tone_on_a [*2] |-> !tone_drive_a) // RULE_03
        else $error("tone driven while disabled");
    a_low_power_bits: assert property (s_tone_write |=> low_power_a == $past(rx_byte[1])
        && low_power_b == $past(rx_byte[5])) // RULE_04
        else $error("low power bits not stored");
    a_input_kind: assert property (s_tone_write |=> tone_input_kind_a == $past(rx_byte[2])
        && tone_input_kind_b == $past(rx_byte[6])) // RULE_06
        else $error("tone input kind bits not stored");
    a_ptr_step_write: assert property (wr_en
        |=> ptr == $past(ptr) + supply_ctrl_pkg::PTR_STEP) // RULE_08
        else $error("pointer did not advance after write");
    a_ptr_step_read: assert property (state == supply_ctrl_pkg::ST_MACK && scl_rise && !sda_s
        |=> ptr == $past(ptr) + supply_ctrl_pkg::PTR_STEP ##0 mack_ok) // RULE_09
        else $error("pointer did not advance after master ack");
    a_tone_on_live: assert property (s_tone_write |=> tone_on_a == $past(rx_byte[0])
        ##0 tone_on_b == $past(rx_byte[4], 1)) // RULE_10
        else $error("tone enable outputs did not follow write");

endmodule : dual_supply_control_regs

// file: logic/pin_sync.sv
`timescale 1ns/10ps
// two-flop synchroniser for asynchronous pins
module pin_sync #(
    parameter int WIDTH = 1,
    parameter logic RESET_VAL = 1'b0
) (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // pins and synchronised copies
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] pin_sync_out
);

    logic [WIDTH-1:0] stage1; // read only by the second stage

    // both stages reset to the idle level of the pins
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            stage1 <= {WIDTH{RESET_VAL}};
            pin_sync_out <= {WIDTH{RESET_VAL}};
        end
        else
        begin
            stage1 <= pin_in;
            pin_sync_out <= stage1;
        end
    end

endmodule : pin_sync

// file: logic/supply_ctrl_pkg.sv
package supply_ctrl_pkg;

    // register addresses on the serial bus
    localparam logic [7:0] REG_VOLT = 8'h02;
    localparam logic [7:0] REG_TONE = 8'h03;

    // reset value of both control bytes
    localparam logic [7:0] CTRL_RESET = 8'h00;
    // value read back from addresses that hold no control byte
    localparam logic [7:0] READ_UNMAPPED = 8'h00;

    // voltage select field positions
    localparam int VOLT_A_LSB = 0;
    localparam int VOLT_B_LSB = 4;
    localparam int VOLT_W = 4;

    // tone and power control bit positions
    localparam int TONE_ON_A = 0;
    localparam int LOW_PWR_A = 1;
    localparam int KIND_A = 2;
    localparam int TONE_ON_B = 4;
    localparam int LOW_PWR_B = 5;
    localparam int KIND_B = 6;

    // bus framing
    localparam logic [2:0] LAST_BIT = 3'h7;
    localparam logic [7:0] PTR_STEP = 8'h01;
    localparam logic BUS_IDLE = 1'b1;

    // serial slave states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_CHIP = 3'b001,
        ST_REG = 3'b010,
        ST_WDATA = 3'b011,
        ST_ACK = 3'b100,
        ST_TX = 3'b101,
        ST_MACK = 3'b110
    } slave_state_t;

endpackage : supply_ctrl_pkg

// file: tb/bus_host.sv
`timescale 1ns/10ps
// behavioural bus master standing in for the host processor
module bus_host #(
    parameter logic [6:0] CHIP = 7'h5A // arbitrary bus address
) (
    // clock
    input wire logic clk,
    // resolved data wire
    input wire logic sda_wire,
    // driven lines
    output logic scl_line,
    output logic sda_pull
);
    // clock stands high and data is released between frames
    initial
    begin
        scl_line = 1'b1;
        sda_pull = 1'b0;
    end

    // wait whole clock cycles
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick

    // one bit slot; 8-cycle phases leave margin over the slave's minimum
    task automatic bit_slot(input logic b, output logic r);
        scl_line <= 1'b0;
        tick(3);
        sda_pull <= ~b;
        tick(5);
        scl_line <= 1'b1;
        tick(4);
        r = sda_wire;
        tick(4);
    endtask : bit_slot

    // start: data falls while the clock is high
    task automatic start_cond();
        sda_pull <= 1'b1;
        tick(6);
    endtask : start_cond

    // stop: data rises while the clock is high, then both lines idle
    task automatic stop_cond();
        scl_line <= 1'b0;
        tick(3);
        sda_pull <= 1'b1;
        tick(5);
        scl_line <= 1'b1;
        tick(6);
        sda_pull <= 1'b0;
        tick(8);
    endtask : stop_cond

    // byte out msb first; acked when the ninth slot reads low
    task automatic send_byte(input logic [7:0] b, output logic acked);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_slot(b[i], r);
        bit_slot(1'b1, r);
        acked = (r === 1'b0);
    endtask : send_byte

    // byte in; a low master ack asks for the next byte
    task automatic recv_byte(input logic more, output logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--)
        begin
            bit_slot(1'b1, r);
            b[i] = r;
        end
        bit_slot(~more, r);
    endtask : recv_byte

    // write one or two data bytes from addr upward
    task automatic write_regs(input logic [6:0] chip, input logic [7:0] addr,
        input logic [7:0] d0, input logic [7:0] d1, input int n, output logic acked);
        logic a;
        start_cond();
        send_byte({chip, 1'b0}, acked);
        send_byte(addr, a);
        acked = acked & a;
        send_byte(d0, a);
        acked = acked & a;
        if (n > 1)
        begin
            send_byte(d1, a);
            acked = acked & a;
        end
        stop_cond();
    endtask : write_regs

    // set the pointer, then stream two bytes, nack on the second
    task automatic read_regs(input logic [7:0] addr, output logic [7:0] q0,
        output logic [7:0] q1, output logic acked);
        logic a;
        start_cond();
        send_byte({CHIP, 1'b0}, acked);
        send_byte(addr, a);
        acked = acked & a;
        stop_cond();
        start_cond();
        send_byte({CHIP, 1'b1}, a);
        acked = acked & a;
        recv_byte(1'b1, q0);
        recv_byte(1'b0, q1);
        stop_cond();
    endtask : read_regs
endmodule : bus_host

// file: tb/tb.sv
`timescale 1ns/10ps
module tb;
    localparam logic [6:0] CHIP = 7'h5A; // arbitrary bus address
    logic clk, resetn, gate_a, gate_b, scl_line, sda_pull, sda_out, sda_oe, ack;
    logic tone_on_a, low_power_a, tone_input_kind_a, tone_drive_a;
    logic tone_on_b, low_power_b, tone_input_kind_b, tone_drive_b;
    logic [3:0] volt_pick_a, volt_pick_b;
    logic [7:0] q0, q1;
    logic [7:0] tone_vals [5] = '{8'h22, 8'h10, 8'h44, 8'h01, 8'h00};
    int n_errors = 0;
    int total_checks = 0;
    wire sda_wire;
    // pull-up wire: low whenever either party pulls it
    assign sda_wire = (sda_oe ? sda_out : 1'b1) & ~sda_pull;

    bus_host #(.CHIP(CHIP)) host (.clk(clk), .sda_wire(sda_wire), .scl_line(scl_line),
        .sda_pull(sda_pull));
    dual_supply_control_regs #(.CHIP_ADDR(CHIP)) dut (.clk(clk), .resetn(resetn),
        .scl_in(scl_line), .sda_in(sda_wire), .sda_out(sda_out), .sda_oe(sda_oe),
        .tone_gate_input_a(gate_a), .tone_gate_input_b(gate_b),
        .volt_pick_a(volt_pick_a), .tone_on_a(tone_on_a), .low_power_a(low_power_a),
        .tone_input_kind_a(tone_input_kind_a), .tone_drive_a(tone_drive_a),
        .volt_pick_b(volt_pick_b), .tone_on_b(tone_on_b), .low_power_b(low_power_b),
        .tone_input_kind_b(tone_input_kind_b), .tone_drive_b(tone_drive_b));

    // 100 ns clock
    always #50 clk = ~clk;

    // verdict and end of run
    task automatic close_out();
        if (n_errors == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : close_out

    // compare one value, report a difference
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // every control output except the gated tone drives against the two stored bytes
    task automatic expect_outputs(input logic [7:0] v, input logic [7:0] t);
        check("volt_pick_a", {4'h0, volt_pick_a}, {4'h0, v[3:0]});
        check("volt_pick_b", {4'h0, volt_pick_b}, {4'h0, v[7:4]});
        check("tone_on_a", {7'h00, tone_on_a}, {7'h00, t[0]});
        check("tone_on_b", {7'h00, tone_on_b}, {7'h00, t[4]});
        check("low_power_a", {7'h00, low_power_a}, {7'h00, t[1]});
        check("low_power_b", {7'h00, low_power_b}, {7'h00, t[5]});
        check("kind_a", {7'h00, tone_input_kind_a}, {7'h00, t[2]});
        check("kind_b", {7'h00, tone_input_kind_b}, {7'h00, t[6]});
    endtask : expect_outputs

    // main sequence
    initial
    begin
        clk = 1'b0;
        resetn = 1'b0;
        gate_a = 1'b0;
        gate_b = 1'b0;
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        host.tick(4);
        expect_outputs(supply_ctrl_pkg::CTRL_RESET, supply_ctrl_pkg::CTRL_RESET);
        // burst write across both control bytes
        host.write_regs(CHIP, supply_ctrl_pkg::REG_VOLT, 8'hAB, 8'h45, 2, ack);
        check("burst ack", {7'h00, ack}, 8'h01);
        expect_outputs(8'hAB, 8'h45);
        // each tone byte: outputs, gated drive, streamed read back
        foreach (tone_vals[k])
        begin
            host.write_regs(CHIP, supply_ctrl_pkg::REG_TONE, tone_vals[k], 8'h00, 1,
                ack);
            expect_outputs(8'hAB, tone_vals[k]);
            gate_a <= 1'b1;
            gate_b <= 1'b1;
            host.tick(6);
            check("drive_a", {7'h00, tone_drive_a}, {7'h00, tone_vals[k][0]});
            check("drive_b", {7'h00, tone_drive_b}, {7'h00, tone_vals[k][4]});
            gate_a <= 1'b0;
            gate_b <= 1'b0;
            host.tick(6);
            check("drive_a off", {7'h00, tone_drive_a}, 8'h00);
            check("drive_b off", {7'h00, tone_drive_b}, 8'h00);
            host.read_regs(supply_ctrl_pkg::REG_VOLT, q0, q1, ack);
            check("read volt", q0, 8'hAB);
            check("read tone", q1, tone_vals[k]);
            check("read ack", {7'h00, ack}, 8'h01);
        end
        // foreign chip address is ignored
        host.write_regs(CHIP ^ 7'h01, supply_ctrl_pkg::REG_VOLT, 8'h12, 8'h00, 1, ack);
        check("foreign ack", {7'h00, ack}, 8'h00);
        // unmapped address takes no control byte
        host.write_regs(CHIP, 8'h07, 8'h5C, 8'h00, 1, ack);
        expect_outputs(8'hAB, 8'h00);
        host.read_regs(8'h07, q0, q1, ack);
        check("unmapped", q0, supply_ctrl_pkg::READ_UNMAPPED);
        close_out();
    end

    // watchdog well beyond the expected 8.5k cycles
    initial
    begin
        #6000000;
        n_errors++;
        close_out();
    end
endmodule : tb
